// >>> rtl/tpg_pkg.sv
// constants, register indices and carrier types of the three-port gpio block
package tpg_pkg;

  // port widths and their place in the flat pin vector
  localparam int unsigned P0_W  = 8;
  localparam int unsigned P1_W  = 7;
  localparam int unsigned P2_W  = 3;
  localparam int unsigned NPIN  = P0_W + P1_W + P2_W;
  localparam int unsigned P0_LSB = 0;
  localparam int unsigned P1_LSB = P0_W;
  localparam int unsigned P2_LSB = P0_W + P1_W;
  localparam int unsigned GH_W  = 6;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_P0_DATA = 8'h80;
  localparam logic [7:0] IDX_P1_DATA = 8'h88;
  localparam logic [7:0] IDX_P0_PU   = 8'h89;
  localparam logic [7:0] IDX_P2_DATA = 8'h90;
  localparam logic [7:0] IDX_P1_PU   = 8'h91;
  localparam logic [7:0] IDX_GUARD_L = 8'h92;
  localparam logic [7:0] IDX_GUARD_H = 8'h93;
  localparam logic [7:0] IDX_P0_DIR  = 8'h98;
  localparam logic [7:0] IDX_P2_PU   = 8'h99;
  localparam logic [7:0] IDX_P1_DIR  = 8'hA0;
  localparam logic [7:0] IDX_P0_OD   = 8'hA1;
  localparam logic [7:0] IDX_P2_DIR  = 8'hB0;
  localparam logic [7:0] IDX_P1_OD   = 8'hB1;
  localparam logic [7:0] IDX_P2_OD   = 8'hB9;
  localparam logic [7:0] IDX_P0_DB   = 8'hC0;
  localparam logic [7:0] IDX_P1_DB   = 8'hC8;
  localparam logic [7:0] IDX_P2_DB   = 8'hD8;
  localparam logic [7:0] IDX_IRQ_ST  = 8'hE1;
  localparam logic [7:0] IDX_IRQ_CLR = 8'hE2;
  localparam logic [7:0] IDX_IRQ_EN  = 8'hE3;

  // reset values
  localparam logic [NPIN-1:0] RST_ZERO = 18'h00000;
  localparam logic [P2_W-1:0] RST_P2_PU = 3'h4;
  localparam logic [7:0]      RST_BYTE  = 8'h00;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per-pin configuration carried as one bundle
  typedef struct packed {
    logic [NPIN-1:0] dout;
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] pu;
    logic [NPIN-1:0] od;
    logic [NPIN-1:0] db;
  } tpg_cfg_t;

  // pad-side signals of all pins
  typedef struct packed {
    logic [NPIN-1:0] o;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] pu;
    logic [NPIN-1:0] ibuf_off;
  } tpg_pad_t;

endpackage

// >>> rtl/tpg_top.sv
// three-port gpio block with axi4-lite register slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tpg_top
  import tpg_pkg::*;
#(
  parameter int unsigned ADDR_W    = 12,
  parameter int unsigned DB_CYCLES = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NPIN-1:0]   pin_i,
  output logic [NPIN-1:0]        pin_o,
  output logic [NPIN-1:0]        pin_oe,
  output logic [NPIN-1:0]        pin_pu_en,
  output logic [NPIN-1:0]        pin_ibuf_off,
  output logic [GH_W-1:0]        analog_guard_high_o,
  output logic                   irq
);

  // elaboration checks on parameters
  if (ADDR_W < 10) begin : g_chk_addr
    $error("ADDR_W must be at least 10");
  end
  if (DB_CYCLES < 2 || DB_CYCLES > 65535) begin : g_chk_db
    $error("DB_CYCLES must lie in 2..65535");
  end

  localparam int unsigned CW = $clog2(DB_CYCLES + 1);
  localparam logic [CW-1:0] DB_LAST = CW'(DB_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ZERO = CW'(0);

  // -------- register state --------
  tpg_cfg_t        cfg_ff;
  logic [7:0]      guard_low_ff;
  logic [GH_W-1:0] guard_high_ff;
  logic [7:0]      irq_en_ff;
  logic [7:0]      irq_st_ff;

  // -------- bus state --------
  logic              aw_held_ff;
  logic              w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0]        wbyte_ff;
  logic              wlane_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [7:0]        rbyte_ff;

  // -------- input path state --------
  logic [NPIN-1:0] sync1_ff;
  logic [NPIN-1:0] sync2_ff;
  logic [NPIN-1:0] stable_ff;
  logic [P0_W-1:0] p0_prev_ff;

  // -------- write channel handshakes --------
  // address and data taken independently, so a master may send either first
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire  = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // -------- write decode --------
  wire [7:0] widx     = awaddr_ff[9:2];
  wire       whigh_ok = (awaddr_ff >> 10) == '0;
  wire       wen      = wr_go & whigh_ok & wlane_ff;
  wire w_p0d = wen & (widx == IDX_P0_DATA);
  wire w_p1d = wen & (widx == IDX_P1_DATA);
  wire w_p2d = wen & (widx == IDX_P2_DATA);
  wire w_p0r = wen & (widx == IDX_P0_DIR);
  wire w_p1r = wen & (widx == IDX_P1_DIR);
  wire w_p2r = wen & (widx == IDX_P2_DIR);
  wire w_p0u = wen & (widx == IDX_P0_PU);
  wire w_p1u = wen & (widx == IDX_P1_PU);
  wire w_p2u = wen & (widx == IDX_P2_PU);
  wire w_p0o = wen & (widx == IDX_P0_OD);
  wire w_p1o = wen & (widx == IDX_P1_OD);
  wire w_p2o = wen & (widx == IDX_P2_OD);
  wire w_p0b = wen & (widx == IDX_P0_DB);
  wire w_p1b = wen & (widx == IDX_P1_DB);
  wire w_p2b = wen & (widx == IDX_P2_DB);
  wire w_gl  = wen & (widx == IDX_GUARD_L);
  wire w_gh  = wen & (widx == IDX_GUARD_H);
  wire w_ien = wen & (widx == IDX_IRQ_EN);
  wire w_clr = wen & (widx == IDX_IRQ_CLR);

  // a write to any listed index answers okay, even with its byte lane off
  wire wmapped = whigh_ok & (
    widx == IDX_P0_DATA || widx == IDX_P1_DATA || widx == IDX_P2_DATA ||
    widx == IDX_P0_DIR  || widx == IDX_P1_DIR  || widx == IDX_P2_DIR  ||
    widx == IDX_P0_PU   || widx == IDX_P1_PU   || widx == IDX_P2_PU   ||
    widx == IDX_P0_OD   || widx == IDX_P1_OD   || widx == IDX_P2_OD   ||
    widx == IDX_P0_DB   || widx == IDX_P1_DB   || widx == IDX_P2_DB   ||
    widx == IDX_GUARD_L || widx == IDX_GUARD_H || widx == IDX_IRQ_ST  ||
    widx == IDX_IRQ_CLR || widx == IDX_IRQ_EN);

  // next values: only the implemented low bits of each port are taken
  wire [P0_W-1:0] wb0 = wbyte_ff[P0_W-1:0];
  wire [P1_W-1:0] wb1 = wbyte_ff[P1_W-1:0];
  wire [P2_W-1:0] wb2 = wbyte_ff[P2_W-1:0];

  tpg_cfg_t nxt_cfg;
  assign nxt_cfg.dout = {w_p2d ? wb2 : cfg_ff.dout[P2_LSB +: P2_W],
                         w_p1d ? wb1 : cfg_ff.dout[P1_LSB +: P1_W],
                         w_p0d ? wb0 : cfg_ff.dout[P0_LSB +: P0_W]};
  assign nxt_cfg.dir  = {w_p2r ? wb2 : cfg_ff.dir[P2_LSB +: P2_W],
                         w_p1r ? wb1 : cfg_ff.dir[P1_LSB +: P1_W],
                         w_p0r ? wb0 : cfg_ff.dir[P0_LSB +: P0_W]};
  assign nxt_cfg.pu   = {w_p2u ? wb2 : cfg_ff.pu[P2_LSB +: P2_W],
                         w_p1u ? wb1 : cfg_ff.pu[P1_LSB +: P1_W],
                         w_p0u ? wb0 : cfg_ff.pu[P0_LSB +: P0_W]};
  assign nxt_cfg.od   = {w_p2o ? wb2 : cfg_ff.od[P2_LSB +: P2_W],
                         w_p1o ? wb1 : cfg_ff.od[P1_LSB +: P1_W],
                         w_p0o ? wb0 : cfg_ff.od[P0_LSB +: P0_W]};
  assign nxt_cfg.db   = {w_p2b ? wb2 : cfg_ff.db[P2_LSB +: P2_W],
                         w_p1b ? wb1 : cfg_ff.db[P1_LSB +: P1_W],
                         w_p0b ? wb0 : cfg_ff.db[P0_LSB +: P0_W]};
  wire [7:0]      nxt_guard_low  = w_gl ? wbyte_ff : guard_low_ff;
  wire [GH_W-1:0] nxt_guard_high = w_gh ? wbyte_ff[GH_W-1:0] : guard_high_ff;
  wire [7:0]      nxt_irq_en     = w_ien ? wbyte_ff : irq_en_ff;

  // config registers; every direction, open-drain, debounce bit clears on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff.dout   <= RST_ZERO;
      cfg_ff.dir    <= RST_ZERO;
      cfg_ff.pu     <= {RST_P2_PU, RST_ZERO[P1_W+P0_W-1:0]};
      cfg_ff.od     <= RST_ZERO;
      cfg_ff.db     <= RST_ZERO;
      guard_low_ff  <= RST_BYTE;
      guard_high_ff <= RST_BYTE[GH_W-1:0];
      irq_en_ff     <= RST_BYTE;
    end else if (ce) begin
      cfg_ff        <= nxt_cfg;
      guard_low_ff  <= nxt_guard_low;
      guard_high_ff <= nxt_guard_high;
      irq_en_ff     <= nxt_irq_en;
    end
  end

  // write channel holding registers and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wbyte_ff   <= RST_BYTE;
      wlane_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else if (ce) begin
      if (aw_fire) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_ff <= 1'b1;
        wbyte_ff  <= s_axi_wdata[7:0];
        wlane_ff  <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wmapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // -------- input path --------
  // two flops for the asynchronous pins; only the second is read onward
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= RST_ZERO;
      sync2_ff <= RST_ZERO;
    end else if (ce) begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
    end
  end

  // per-pin debounce; a disabled filter follows the synchronised level at once
  for (genvar g = 0; g < NPIN; g++) begin : g_db
    logic [CW-1:0] cnt_ff;
    wire           differs = sync2_ff[g] ^ stable_ff[g];
    wire           settled = differs & (cnt_ff == DB_LAST);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_ff       <= CNT_ZERO;
        stable_ff[g] <= 1'b0;
      end else if (ce) begin
        if (!cfg_ff.db[g] || settled) begin
          cnt_ff       <= CNT_ZERO;
          stable_ff[g] <= sync2_ff[g];
        end else if (differs) begin
          cnt_ff <= cnt_ff + CW'(1);
        end else begin
          cnt_ff <= CNT_ZERO; // glitch back to old level restarts the wait
        end
      end
    end
  end

  // guard mask on the flat pin vector: channels 0..7 on the first port,
  // 8 and 9 on second-port pins 4 and 5; channels 10..13 sit off these ports
  wire [NPIN-1:0] guard_mask = {4'h0, guard_high_ff[1:0], 4'h0, guard_low_ff};
  wire [NPIN-1:0] pin_level  = stable_ff & ~guard_mask;

  // -------- pad drive --------
  // open-drain pins only ever pull low; the high level is the board's resistor
  tpg_pad_t pad;
  assign pad.o        = cfg_ff.dout & ~cfg_ff.od;
  assign pad.oe       = cfg_ff.dir & (~cfg_ff.od | ~cfg_ff.dout);
  assign pad.pu       = cfg_ff.pu & ~cfg_ff.dir;
  assign pad.ibuf_off = guard_mask;
  assign pin_o        = pad.o;
  assign pin_oe       = pad.oe;
  assign pin_pu_en    = pad.pu;
  assign pin_ibuf_off = pad.ibuf_off;
  assign analog_guard_high_o = guard_high_ff;

  // -------- change interrupt on the first port --------
  // outputs drive their own level back, so an output pin may flag too
  wire [P0_W-1:0] p0_change = pin_level[P0_LSB +: P0_W] ^ p0_prev_ff;
  wire [7:0]      irq_clr   = w_clr ? wbyte_ff : RST_BYTE;
  wire [7:0]      nxt_irq_st = (irq_st_ff & ~irq_clr) | p0_change; // set beats clear

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p0_prev_ff <= RST_BYTE;
      irq_st_ff  <= RST_BYTE;
    end else if (ce) begin
      p0_prev_ff <= pin_level[P0_LSB +: P0_W];
      irq_st_ff  <= nxt_irq_st;
    end
  end

  assign irq = |(irq_st_ff & irq_en_ff);

  // -------- read channel --------
  wire [7:0] ridx     = s_axi_araddr[9:2];
  wire       rhigh_ok = (s_axi_araddr >> 10) == '0;
  wire       ar_fire  = s_axi_arvalid & s_axi_arready;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = {24'h000000, rbyte_ff};

  // data bit reads the latch on outputs and the pin level on inputs
  wire [NPIN-1:0] port_rd = (cfg_ff.dir & cfg_ff.dout) | (~cfg_ff.dir & pin_level);

  logic [7:0] rd_byte;
  logic       rd_hit;
  // read mux; missing upper bits are zero-filled
  always_comb begin
    rd_byte = RST_BYTE;
    rd_hit  = 1'b1;
    case (ridx)
      IDX_P0_DATA: rd_byte = port_rd[P0_LSB +: P0_W];
      IDX_P1_DATA: rd_byte = {1'b0, port_rd[P1_LSB +: P1_W]};
      IDX_P2_DATA: rd_byte = {5'h00, port_rd[P2_LSB +: P2_W]};
      IDX_P0_DIR:  rd_byte = cfg_ff.dir[P0_LSB +: P0_W];
      IDX_P1_DIR:  rd_byte = {1'b0, cfg_ff.dir[P1_LSB +: P1_W]};
      IDX_P2_DIR:  rd_byte = {5'h00, cfg_ff.dir[P2_LSB +: P2_W]};
      IDX_P0_PU:   rd_byte = cfg_ff.pu[P0_LSB +: P0_W];
      IDX_P1_PU:   rd_byte = {1'b0, cfg_ff.pu[P1_LSB +: P1_W]};
      IDX_P2_PU:   rd_byte = {5'h00, cfg_ff.pu[P2_LSB +: P2_W]};
      IDX_P0_OD:   rd_byte = cfg_ff.od[P0_LSB +: P0_W];
      IDX_P1_OD:   rd_byte = {1'b0, cfg_ff.od[P1_LSB +: P1_W]};
      IDX_P2_OD:   rd_byte = {5'h00, cfg_ff.od[P2_LSB +: P2_W]};
      IDX_P0_DB:   rd_byte = cfg_ff.db[P0_LSB +: P0_W];
      IDX_P1_DB:   rd_byte = {1'b0, cfg_ff.db[P1_LSB +: P1_W]};
      IDX_P2_DB:   rd_byte = {5'h00, cfg_ff.db[P2_LSB +: P2_W]};
      IDX_GUARD_L: rd_byte = guard_low_ff;
      IDX_GUARD_H: rd_byte = {2'h0, guard_high_ff};
      IDX_IRQ_ST:  rd_byte = irq_st_ff;
      IDX_IRQ_EN:  rd_byte = irq_en_ff;
      IDX_IRQ_CLR: rd_byte = RST_BYTE; // write-only, reads zero
      default:     rd_hit  = 1'b0;
    endcase
  end

  // read response registered; one read outstanding at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rbyte_ff  <= RST_BYTE;
    end else if (ce) begin
      if (ar_fire) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= (rd_hit & rhigh_ok) ? RESP_OKAY : RESP_SLVERR;
        rbyte_ff  <= (rd_hit & rhigh_ok) ? rd_byte : RST_BYTE;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// >>> dv/tpg_top_asserts.sv
// assertion checker for the three-port gpio block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module tpg_chk
  import tpg_pkg::*;
(
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [NPIN-1:0] pin_o,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] pin_pu_en,
  input wire logic [NPIN-1:0] pin_ibuf_off,
  input wire logic [GH_W-1:0] analog_guard_high_o,
  input wire logic            irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both halves of a write taken together, and a read address taken
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_rst_pins;
    $rose(aresetn) |-> pin_oe == '0 && pin_o == '0 && pin_pu_en == 18'h20000 && !irq
      && pin_ibuf_off == '0;
  endproperty
  property p_pu_input;
    (pin_pu_en & pin_oe) == '0;
  endproperty
  property p_guard_map;
    pin_ibuf_off[13:12] == analog_guard_high_o[1:0] && pin_ibuf_off[17:14] == 4'h0
      && pin_ibuf_off[11:8] == 4'h0;
  endproperty
  property p_rdata_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  // write answer lands two edges after the taking edge
  property p_wr_answer;
    s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_rst_pins: assert property (p_rst_pins)
    else $error("pins not idle after reset");
  a_pu_input: assert property (p_pu_input)
    else $error("pull-up on a driven pin");
  a_guard_map: assert property (p_guard_map)
    else $error("guard mask misplaced");
  a_rdata_upper: assert property (p_rdata_upper)
    else $error("upper read bits set");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer late or early");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped");
  a_w_refuse: assert property (p_w_refuse)
    else $error("write taken while answer pending");
endmodule
bind tpg_top tpg_chk i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_o(pin_o), .pin_oe(pin_oe),
  .pin_pu_en(pin_pu_en), .pin_ibuf_off(pin_ibuf_off),
  .analog_guard_high_o(analog_guard_high_o), .irq(irq)
);
`default_nettype wire

// >>> dv/tpg_pad_model.sv
// board-side model of the pads: drivers, pull resistors, floating lines
`timescale 1ns/1ps
`default_nettype none
module tpg_pad_model
  import tpg_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic [NPIN-1:0] pin_o,
  input  wire logic [NPIN-1:0] pin_oe,
  input  wire logic [NPIN-1:0] pin_pu_en,
  input  wire logic [NPIN-1:0] ext_en,
  input  wire logic [NPIN-1:0] ext_val,
  input  wire logic [NPIN-1:0] board_pull,
  output logic      [NPIN-1:0] pin_i
);
  // a free line wanders so that no stale level passes for a real one
  logic [NPIN-1:0] float_ff = 18'h2AAAA;
  always_ff @(posedge aclk) begin
    float_ff <= ~float_ff;
  end
  // device drive wins, then the board driver, then pull resistors
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pin_oe[i]) pin_i[i] = pin_o[i];
      else if (ext_en[i]) pin_i[i] = ext_val[i];
      else if (pin_pu_en[i] || board_pull[i]) pin_i[i] = 1'b1;
      else pin_i[i] = float_ff[i];
    end
  end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench of the three-port gpio block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tpg_pkg::*;
();
  localparam int unsigned DBC = 3;
  logic            aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic            awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0]     awaddr, araddr;
  logic [31:0]     wdata, rdata, r, g;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp, hi;
  logic [NPIN-1:0] pin_i, pin_o, pin_oe, pin_pu_en, pin_ibuf_off, ext_en, ext_val, board_pull;
  logic [GH_W-1:0] guard_hi;
  logic [7:0]      val [18];
  int              n, bad_count, n_tests;
  // register table: pull-up, open-drain, debounce, direction, guard, data, irq enable
  logic [7:0] idx [18] = '{IDX_P0_PU, IDX_P1_PU, IDX_P2_PU, IDX_P0_OD, IDX_P1_OD, IDX_P2_OD,
    IDX_P0_DB, IDX_P1_DB, IDX_P2_DB, IDX_P0_DIR, IDX_P1_DIR, IDX_P2_DIR, IDX_GUARD_L,
    IDX_GUARD_H, IDX_P0_DATA, IDX_P1_DATA, IDX_P2_DATA, IDX_IRQ_EN};
  logic [7:0] msk [18] = '{8'hFF, 8'h7F, 8'h07, 8'hFF, 8'h7F, 8'h07, 8'hFF, 8'h7F, 8'h07,
    8'hFF, 8'h7F, 8'h07, 8'hFF, 8'h3F, 8'hFF, 8'h7F, 8'h07, 8'hFF};

  tpg_top #(.DB_CYCLES(DBC)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu_en(pin_pu_en),
    .pin_ibuf_off(pin_ibuf_off), .analog_guard_high_o(guard_hi), .irq(irq)
  );
  tpg_pad_model i_pads (
    .aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu_en(pin_pu_en), .ext_en(ext_en),
    .ext_val(ext_val), .board_pull(board_pull), .pin_i(pin_i)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // pin vector of one register kind across the three ports
  function automatic logic [NPIN-1:0] vec(input int b);
    return {val[b+2][2:0], val[b+1][6:0], val[b]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // answer is awaited, never assumed; only the watchdog ends a hang
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= {hi, i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {hi, i, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    chk(rdata, {24'h0, e});
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic tally_and_finish();
    $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a tenth of this
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, hi, ext_val, board_pull} = '0;
    ce = 1'b1;
    wstrb = 4'hF;
    ext_en = '1;
    r = $urandom(32'h39C1);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 18; i++) rd(idx[i], (i == 2) ? 8'h04 : 8'h00, RESP_OKAY);
    // random configuration, unimplemented bits must drop
    for (int i = 0; i < 14; i++) begin
      r = $urandom;
      val[i] = r[7:0] & msk[i];
      wr(idx[i], r[7:0], RESP_OKAY);
      rd(idx[i], val[i], RESP_OKAY);
    end
    chk({14'h0, pin_pu_en}, {14'h0, vec(0) & ~vec(9)});
    chk({14'h0, pin_oe}, {14'h0, vec(9)});
    chk({26'h0, guard_hi}, {24'h0, val[13]});
    // all pins out, random data through push-pull and open-drain
    for (int i = 9; i < 12; i++) begin
      val[i] = msk[i];
      wr(idx[i], 8'hFF, RESP_OKAY);
    end
    board_pull <= vec(3);
    for (int i = 14; i < 17; i++) begin
      r = $urandom;
      val[i] = r[7:0] & msk[i];
      wr(idx[i], r[7:0], RESP_OKAY);
      rd(idx[i], val[i], RESP_OKAY);
    end
    chk({14'h0, pin_o}, {14'h0, vec(14) & ~vec(3)});
    chk({14'h0, pin_oe}, {14'h0, vec(9) & (~vec(3) | ~vec(14))});
    // inputs: debounce, direction and guard cleared
    for (int i = 6; i < 14; i++) wr(idx[i], 8'h00, RESP_OKAY);
    r = $urandom;
    g = $urandom;
    ext_val <= r[17:0];
    repeat (4) @(posedge aclk);
    rd(idx[14], r[7:0], RESP_OKAY);
    rd(idx[16], {5'h0, r[17:15]}, RESP_OKAY);
    wr(idx[12], g[7:0], RESP_OKAY);
    wr(idx[13], g[15:8], RESP_OKAY);
    rd(idx[14], r[7:0] & ~g[7:0], RESP_OKAY);
    rd(idx[15], {1'b0, r[14:8]} & ~{2'b00, g[9:8], 4'h0}, RESP_OKAY);
    chk({14'h0, pin_ibuf_off}, {14'h0, 4'h0, g[9:8], 4'h0, g[7:0]});
    for (int i = 12; i < 14; i++) wr(idx[i], 8'h00, RESP_OKAY);
    // change interrupt: raise, mask, clear
    wr(IDX_IRQ_EN, 8'hFF, RESP_OKAY);
    wr(IDX_IRQ_CLR, 8'hFF, RESP_OKAY);
    rd(IDX_IRQ_ST, 8'h00, RESP_OKAY);
    n = $urandom_range(7, 0);
    ext_val[n] <= ~r[n];
    repeat (6) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_ST, 8'h00, RESP_OKAY);
    rd(IDX_IRQ_ST, 8'h01 << n, RESP_OKAY);
    wr(IDX_IRQ_EN, 8'h00, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_CLR, 8'hFF, RESP_OKAY);
    rd(IDX_IRQ_ST, 8'h00, RESP_OKAY);
    // debounce: a glitch one short of the count is dropped
    wr(idx[6], 8'hFF, RESP_OKAY);
    ext_val[n] <= r[n];
    repeat (DBC - 1) @(posedge aclk);
    ext_val[n] <= ~r[n];
    repeat (DBC + 6) @(posedge aclk);
    rd(IDX_IRQ_ST, 8'h00, RESP_OKAY);
    ext_val[n] <= r[n];
    repeat (DBC + 6) @(posedge aclk);
    rd(IDX_IRQ_ST, 8'h01 << n, RESP_OKAY);
    // clock enable low: a long pin pulse must leave no trace in the filter
    wr(IDX_IRQ_CLR, 8'hFF, RESP_OKAY);
    ce <= 1'b0;
    ext_val[n] <= ~r[n];
    repeat (DBC + 6) @(posedge aclk);
    ext_val[n] <= r[n];
    repeat (2) @(posedge aclk);
    ce <= 1'b1;
    repeat (DBC + 6) @(posedge aclk);
    rd(IDX_IRQ_ST, 8'h00, RESP_OKAY);
    // unmapped index; the out-of-range upper address follows the byte lane check
    wr(8'h81, 8'h5A, RESP_SLVERR);
    rd(8'h81, 8'h00, RESP_SLVERR);
    // byte lane off: answered okay but the register keeps its value
    wstrb <= 4'hE;
    wr(idx[0], ~val[0], RESP_OKAY);
    wstrb <= 4'hF;
    rd(idx[0], val[0], RESP_OKAY);
    hi = 2'b10;
    rd(idx[0], 8'h00, RESP_SLVERR);
    hi = 2'b00;
    tally_and_finish();
  end
endmodule
`default_nettype wire
